// file: rtl/vssc_defs.vh
// Register offsets, field positions and reset values for the sprite surface config block
`ifndef VSSC_DEFS_VH
`define VSSC_DEFS_VH
`define VSSC_ADDR_W          20
`define VSSC_OFS_LINEAR      20'h72184
`define VSSC_OFS_STRIDE      20'h72188
`define VSSC_OFS_POSITION    20'h7218C
`define VSSC_OFS_CONTROL     20'h72180
`define VSSC_OFS_SURFACE     20'h7219C
`define VSSC_RST_WORD        32'h00000000
`define VSSC_CTL_TILED_BIT   10
`define VSSC_CTL_DKEY_BIT    2
`define VSSC_CTL_ROT_BIT     15
`define VSSC_CTL_ORDER_HI    17
`define VSSC_CTL_ORDER_LO    16
`define VSSC_STRIDE_HI       14
`define VSSC_STRIDE_LO       6
`define VSSC_POS_Y_HI        27
`define VSSC_POS_Y_LO        16
`define VSSC_POS_X_HI        11
`define VSSC_POS_X_LO        0
`define VSSC_ORD_YUYV        2'h0
`define VSSC_ORD_UYVY        2'h1
`define VSSC_ORD_YVYU        2'h2
`define VSSC_ORD_VYUY        2'h3
`endif

// file: rtl/vssc_yuv_unpack.v
// Byte to channel mapping of one packed YUV 4:2:2 pixel pair
`include "vssc_defs.vh"
`default_nettype none
module vssc_yuv_unpack (
  input  wire [31:0] pix_word,
  input  wire [1:0]  byte_order,
  output reg  [7:0]  y1,
  output reg  [7:0]  u,
  output reg  [7:0]  y2,
  output reg  [7:0]  v
);
  always @* begin
    y1 = pix_word[7:0];
    u  = pix_word[15:8];
    y2 = pix_word[23:16];
    v  = pix_word[31:24];
    case (byte_order)
      `VSSC_ORD_YUYV: begin
        y1 = pix_word[7:0];
        u  = pix_word[15:8];
        y2 = pix_word[23:16];
        v  = pix_word[31:24];
      end
      `VSSC_ORD_UYVY: begin
        y1 = pix_word[15:8];
        u  = pix_word[7:0];
        y2 = pix_word[31:24];
        v  = pix_word[23:16];
      end
      `VSSC_ORD_YVYU: begin
        y1 = pix_word[7:0];
        u  = pix_word[31:24];
        y2 = pix_word[23:16];
        v  = pix_word[15:8];
      end
      `VSSC_ORD_VYUY: begin
        y1 = pix_word[15:8];
        u  = pix_word[23:16];
        y2 = pix_word[31:24];
        v  = pix_word[7:0];
      end
      default: begin
        y1 = pix_word[7:0];
        u  = pix_word[15:8];
        y2 = pix_word[23:16];
        v  = pix_word[31:24];
      end
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/vssc_dest_key.v
// Destination colour key pixel select
`default_nettype none
module vssc_dest_key (
  input  wire        key_en,
  input  wire [23:0] key_value,
  input  wire [23:0] key_mask,
  input  wire [23:0] primary_pix,
  input  wire [23:0] sprite_pix,
  output wire [23:0] out_pix
);
  wire match;
  // Mask zero bits ignore mismatches
  assign match   = ((primary_pix ^ key_value) & key_mask) == 24'h000000;
  assign out_pix = (key_en && match) ? sprite_pix : primary_pix;
endmodule
`default_nettype wire

// file: rtl/vssc_top.v
// Sprite surface configuration registers with vertical blank double buffering
`include "vssc_defs.vh"
`default_nettype none
module vssc_top #(
  parameter ADDR_W = `VSSC_ADDR_W
) (
  input  wire              ref_clk,
  input  wire              resetn,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [31:0]       reg_wdata,
  output reg  [31:0]       reg_rdata,
  input  wire              cmd_stride_vld,
  input  wire [31:0]       cmd_stride_data,
  input  wire              vblank_start,
  input  wire              pipe_enable,
  input  wire              sprite_enable,
  input  wire [31:0]       surface_base,
  input  wire [31:0]       pix_word,
  input  wire [23:0]       key_value,
  input  wire [23:0]       key_mask,
  input  wire [23:0]       primary_pix,
  input  wire [23:0]       sprite_pix,
  output reg               tiled_mode,
  output reg               rotate_180,
  output reg  [31:0]       start_addr,
  output reg  [8:0]        stride_active,
  output reg  [11:0]       pos_x_active,
  output reg  [11:0]       pos_y_active,
  output reg  [7:0]        chan_y1,
  output reg  [7:0]        chan_u,
  output reg  [7:0]        chan_y2,
  output reg  [7:0]        chan_v,
  output reg  [23:0]       blend_pix
);
  reg  [31:0] control_r;
  reg  [31:0] lin_pend_r;
  reg  [31:0] lin_act_r;
  reg  [8:0]  stride_pend_r;
  reg  [11:0] posx_pend_r;
  reg  [11:0] posy_pend_r;
  reg         armed_r;
  reg         pipe_en_d_r;
  reg         spr_en_d_r;
  wire        wr_ctl;
  wire        wr_lin;
  wire        wr_str;
  wire        wr_pos;
  wire        wr_surf;
  wire        pipe_off;
  wire        spr_fall;
  wire        lin_load;
  wire        arm_load;
  wire [31:0] lin_next;
  wire [8:0]  str_next;
  wire [7:0]  un_y1;
  wire [7:0]  un_u;
  wire [7:0]  un_y2;
  wire [7:0]  un_v;
  wire [23:0] key_pix;

  assign wr_ctl   = reg_wr && (reg_addr == `VSSC_OFS_CONTROL);
  assign wr_lin   = reg_wr && (reg_addr == `VSSC_OFS_LINEAR);
  assign wr_str   = reg_wr && (reg_addr == `VSSC_OFS_STRIDE);
  assign wr_pos   = reg_wr && (reg_addr == `VSSC_OFS_POSITION);
  assign wr_surf  = reg_wr && (reg_addr == `VSSC_OFS_SURFACE);
  assign pipe_off = !pipe_enable;
  assign spr_fall = spr_en_d_r && !sprite_enable;
  // A pending write in the same cycle as the load point goes straight through
  assign lin_next = wr_lin ? reg_wdata : lin_pend_r;
  assign lin_load = vblank_start || pipe_off;
  // Register write takes precedence over a command packet in the same cycle
  assign str_next = wr_str ? reg_wdata[`VSSC_STRIDE_HI:`VSSC_STRIDE_LO] :
                    cmd_stride_data[`VSSC_STRIDE_HI:`VSSC_STRIDE_LO];
  assign arm_load = (armed_r || wr_surf) && (vblank_start || pipe_off || spr_fall);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      control_r     <= `VSSC_RST_WORD;
      lin_pend_r    <= `VSSC_RST_WORD;
      lin_act_r     <= `VSSC_RST_WORD;
      stride_pend_r <= 9'h000;
      posx_pend_r   <= 12'h000;
      posy_pend_r   <= 12'h000;
      armed_r       <= 1'b0;
      pipe_en_d_r   <= 1'b0;
      spr_en_d_r    <= 1'b0;
      stride_active <= 9'h000;
      pos_x_active  <= 12'h000;
      pos_y_active  <= 12'h000;
    end else begin
      pipe_en_d_r <= pipe_enable;
      spr_en_d_r  <= sprite_enable;
      if (wr_ctl) begin
        control_r <= reg_wdata;
      end
      if (wr_lin) begin
        lin_pend_r <= reg_wdata;
      end
      if (lin_load) begin
        lin_act_r <= lin_next;
      end
      if (wr_str || cmd_stride_vld) begin
        stride_pend_r <= str_next;
      end
      if (wr_pos) begin
        posx_pend_r <= reg_wdata[`VSSC_POS_X_HI:`VSSC_POS_X_LO];
        posy_pend_r <= reg_wdata[`VSSC_POS_Y_HI:`VSSC_POS_Y_LO];
      end
      if (arm_load) begin
        stride_active <= (wr_str || cmd_stride_vld) ? str_next : stride_pend_r;
        pos_x_active  <= wr_pos ? reg_wdata[`VSSC_POS_X_HI:`VSSC_POS_X_LO] : posx_pend_r;
        pos_y_active  <= wr_pos ? reg_wdata[`VSSC_POS_Y_HI:`VSSC_POS_Y_LO] : posy_pend_r;
        armed_r       <= 1'b0;
      end else if (wr_surf) begin
        armed_r <= 1'b1;
      end
    end
  end

  // Read returns pending copies; stride and position reserved bits read zero, control reads back as written, unmapped reads zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `VSSC_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        `VSSC_OFS_CONTROL:  reg_rdata <= control_r;
        `VSSC_OFS_LINEAR:   reg_rdata <= lin_pend_r;
        `VSSC_OFS_STRIDE:   reg_rdata <= {17'h00000, stride_pend_r, 6'h00};
        `VSSC_OFS_POSITION: reg_rdata <= {4'h0, posy_pend_r, 4'h0, posx_pend_r};
        default:            reg_rdata <= `VSSC_RST_WORD;
      endcase
    end
  end

  vssc_yuv_unpack u_unpack (
    .pix_word   (pix_word),
    .byte_order (control_r[`VSSC_CTL_ORDER_HI:`VSSC_CTL_ORDER_LO]),
    .y1         (un_y1),
    .u          (un_u),
    .y2         (un_y2),
    .v          (un_v)
  );

  vssc_dest_key u_key (
    .key_en      (control_r[`VSSC_CTL_DKEY_BIT]),
    .key_value   (key_value),
    .key_mask    (key_mask),
    .primary_pix (primary_pix),
    .sprite_pix  (sprite_pix),
    .out_pix     (key_pix)
  );

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tiled_mode <= 1'b0;
      rotate_180 <= 1'b0;
      start_addr <= `VSSC_RST_WORD;
      chan_y1    <= 8'h00;
      chan_u     <= 8'h00;
      chan_y2    <= 8'h00;
      chan_v     <= 8'h00;
      blend_pix  <= 24'h000000;
    end else begin
      // Tiled layout is X-major only; the fetch side uses tile addressing
      tiled_mode <= control_r[`VSSC_CTL_TILED_BIT];
      // Position fields are taken as lower-right corner by the fetch when set
      rotate_180 <= control_r[`VSSC_CTL_ROT_BIT];
      if (control_r[`VSSC_CTL_TILED_BIT]) begin
        start_addr <= surface_base;
      end else begin
        start_addr <= surface_base + lin_act_r;
      end
      chan_y1   <= un_y1;
      chan_u    <= un_u;
      chan_y2   <= un_y2;
      chan_v    <= un_v;
      blend_pix <= key_pix;
    end
  end

  // Unused state of the delayed pipe enable is kept for a clean falling edge view
  wire unused_pipe_d;
  assign unused_pipe_d = pipe_en_d_r;
endmodule
`default_nettype wire

// file: bench/vssc_props.sv
// Port-level assertions for the sprite surface config block
`include "vssc_defs.vh"
`default_nettype none
module vssc_props #(
  parameter ADDR_W = 20
) (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic [31:0]       reg_rdata,
  input wire logic              vblank_start,
  input wire logic              pipe_enable,
  input wire logic              sprite_enable,
  input wire logic [31:0]       surface_base,
  input wire logic              tiled_mode,
  input wire logic [31:0]       start_addr,
  input wire logic [8:0]        stride_active,
  input wire logic [11:0]       pos_x_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_q;
  wire  ctl_wr = reg_wr && reg_addr == `VSSC_OFS_CONTROL;
  // Any point at which an armed double buffer may load
  wire  ld     = vblank_start || !pipe_enable || (en_q && !sprite_enable);
  always @(posedge ref_clk or negedge resetn)
    if (!resetn) en_q <= 1'b0;
    else en_q <= sprite_enable;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_tiled_follow: assert property (ctl_wr ##2 1 |-> tiled_mode == $past(reg_wdata[10], 2))
    else $error("tiled mode not written value");
  chk_tiled_source: assert property ($changed(tiled_mode) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("tiled mode changed unprompted");
  chk_linear_ignored: assert property (tiled_mode && $past(tiled_mode) && $stable(surface_base)
    |-> start_addr == surface_base) else $error("tiled start not base");
  chk_stride_load: assert property ($changed(stride_active) |-> $past(ld) || $past(ld, 2))
    else $error("stride changed off load point");
  chk_pos_load: assert property ($changed(pos_x_active) |-> $past(ld) || $past(ld, 2))
    else $error("position changed off load point");
  chk_stride_rsvd: assert property (reg_rd && reg_addr == `VSSC_OFS_STRIDE
    |=> (reg_rdata & 32'hFFFF803F) == 32'h0) else $error("stride reserved bits set");
  chk_pos_rsvd: assert property (reg_rd && reg_addr == `VSSC_OFS_POSITION
    |=> (reg_rdata & 32'hF000F000) == 32'h0) else $error("position reserved bits set");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule
bind vssc_top vssc_props #(.ADDR_W(ADDR_W)) vssc_props_i (.ref_clk, .resetn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .vblank_start, .pipe_enable, .sprite_enable, .surface_base,
  .tiled_mode, .start_addr, .stride_active, .pos_x_active);
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the sprite surface config block
`include "vssc_defs.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, resetn, reg_wr, reg_rd, cmd_stride_vld, vblank_start;
  logic        pipe_enable, sprite_enable, tiled_mode, rotate_180;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cmd_stride_data, surface_base, pix_word, start_addr, v;
  logic [23:0] key_value, key_mask, primary_pix, sprite_pix, blend_pix;
  logic [8:0]  stride_active;
  logic [11:0] pos_x_active, pos_y_active;
  logic [7:0]  chan_y1, chan_u, chan_y2, chan_v;
  int          errors, n_checks;
  vssc_top vssc_top_i (.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .cmd_stride_vld, .cmd_stride_data, .vblank_start, .pipe_enable, .sprite_enable,
    .surface_base, .pix_word, .key_value, .key_mask, .primary_pix, .sprite_pix, .tiled_mode,
    .rotate_180, .start_addr, .stride_active, .pos_x_active, .pos_y_active, .chan_y1,
    .chan_u, .chan_y2, .chan_v, .blend_pix);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic vb();
    @(posedge ref_clk);
    vblank_start <= 1'b1;
    @(posedge ref_clk);
    vblank_start <= 1'b0;
    tk(2);
  endtask
  task automatic t_regs();
    rd(`VSSC_OFS_LINEAR);
    `CHK("linear reset", 32'h0, v)
    // Reserved bits set, stride field kept at a legal 16320 bytes
    wr(`VSSC_OFS_STRIDE, 32'hFFFFBFFF);
    wr(`VSSC_OFS_POSITION, 32'hF123F456);
    rd(`VSSC_OFS_STRIDE);
    `CHK("stride read", 32'h00003FC0, v)
    rd(`VSSC_OFS_POSITION);
    `CHK("position read", 32'h01230456, v)
    vb();
    `CHK("unarmed stride", 9'h000, stride_active)
    wr(`VSSC_OFS_SURFACE, 32'h0);
    tk(2);
    `CHK("armed early", 9'h000, stride_active)
    vb();
    `CHK("stride", 9'h0FF, stride_active)
    `CHK("position", 24'h123456, {pos_y_active, pos_x_active})
    @(posedge ref_clk);
    cmd_stride_vld <= 1'b1;
    cmd_stride_data <= 32'h00000400;
    @(posedge ref_clk);
    cmd_stride_vld <= 1'b0;
    wr(`VSSC_OFS_SURFACE, 32'h0);
    @(posedge ref_clk);
    sprite_enable <= 1'b0;
    tk(3);
    `CHK("packet stride", 9'h010, stride_active)
    @(posedge ref_clk);
    sprite_enable <= 1'b1;
    $display("test regs done");
  endtask
  task automatic t_addr();
    @(posedge ref_clk);
    surface_base <= 32'h10000000;
    wr(`VSSC_OFS_LINEAR, 32'h00000100);
    tk(2);
    `CHK("pending offset", 32'h10000000, start_addr)
    vb();
    `CHK("linear start", 32'h10000100, start_addr)
    wr(`VSSC_OFS_CONTROL, 32'h00000400);
    tk(3);
    `CHK("tiled", 1'b1, tiled_mode)
    `CHK("tiled start", 32'h10000000, start_addr)
    wr(`VSSC_OFS_CONTROL, 32'h0);
    @(posedge ref_clk);
    pipe_enable <= 1'b0;
    wr(`VSSC_OFS_LINEAR, 32'h00000200);
    tk(3);
    `CHK("pipe off start", 32'h10000200, start_addr)
    `CHK("linear", 1'b0, tiled_mode)
    @(posedge ref_clk);
    pipe_enable <= 1'b1;
    wr(`VSSC_OFS_LINEAR, 32'h00000FFC);
    wr(`VSSC_OFS_CONTROL, 32'h00008000);
    tk(3);
    `CHK("rotate", 1'b1, rotate_180)
    rd(`VSSC_OFS_CONTROL);
    `CHK("control read", 32'h00008000, v)
    rd(`VSSC_OFS_SURFACE);
    `CHK("surface read", 32'h00000000, v)
    wr(`VSSC_OFS_CONTROL, 32'h0);
    tk(3);
    `CHK("rotate off", 1'b0, rotate_180)
    $display("test address done");
  endtask
  task automatic t_yuv();
    logic [31:0] ex [4] = '{32'h11223344, 32'h22114433, 32'h11443322, 32'h22334411};
    @(posedge ref_clk);
    pix_word <= 32'h44332211;
    for (int o = 0; o < 4; o++) begin
      wr(`VSSC_OFS_CONTROL, 32'(o) << 16);
      tk(3);
      `CHK("yuv map", ex[o], {chan_y1, chan_u, chan_y2, chan_v})
    end
    $display("test yuv done");
  endtask
  task automatic t_key();
    @(posedge ref_clk);
    key_value <= 24'hABCDEF;
    key_mask <= 24'hFFFFFF;
    sprite_pix <= 24'h123456;
    primary_pix <= 24'hABCDEF;
    wr(`VSSC_OFS_CONTROL, 32'h00000004);
    tk(3);
    `CHK("key match", 24'h123456, blend_pix)
    @(posedge ref_clk);
    primary_pix <= 24'hABCDEE;
    tk(3);
    `CHK("key miss", 24'hABCDEE, blend_pix)
    @(posedge ref_clk);
    key_mask <= 24'hFFFFFE;
    tk(3);
    `CHK("masked bit", 24'h123456, blend_pix)
    wr(`VSSC_OFS_CONTROL, 32'h0);
    tk(3);
    `CHK("key off", 24'hABCDEE, blend_pix)
    $display("test key done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, cmd_stride_vld, vblank_start, reg_addr, reg_wdata} = '0;
    {cmd_stride_data, surface_base, pix_word} = '0;
    {key_value, key_mask, primary_pix, sprite_pix} = '0;
    {pipe_enable, sprite_enable, resetn} = 3'b110;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_addr();
    t_yuv();
    t_key();
    results();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
